// file: verilog/ldocr_defines.svh
// Purpose: offsets, field positions and reset values of the regulator control registers
// Assumes: eight-bit registers reached by an eight-bit address
// Notes: definitions only
`ifndef LDOCR_DEFINES_SVH
`define LDOCR_DEFINES_SVH
`define LDOCR_ADDR_A_CFG 8'h03
`define LDOCR_ADDR_MISC 8'h40
`define LDOCR_ADDR_B_CFG 8'h41
`define LDOCR_ADDR_C_CFG 8'h42
`define LDOCR_ADDR_STAT 8'h43
`define LDOCR_A_RANGE_BIT 6
`define LDOCR_ON_BIT 5
`define LDOCR_DIS_A_BIT 2
`define LDOCR_DIS_B_BIT 3
`define LDOCR_DIS_C_BIT 4
`define LDOCR_PG_A_BIT 5
`define LDOCR_PG_B_BIT 6
`define LDOCR_PG_C_BIT 7
`define LDOCR_WE_MISC_BIT 5
`define LDOCR_WE_STAT_BIT 1
`define LDOCR_RST_A_CODE 6'h00
`define LDOCR_RST_BC_CODE 5'h00
`define LDOCR_RST_BIT 1'b0
// first-regulator codes above this are unavailable in the high range
`define LDOCR_A_HI_MAX_CODE 6'h31
`endif

// file: verilog/ldocr_pkg.sv
// Purpose: shared types of the regulator control block
// Assumes: used with ldocr_defines.svh
// Notes: voltages carried in millivolts
package ldocr_pkg;
  typedef logic [11:0] ldocr_mv_t;
endpackage

// file: verilog/ldocr_regs.sv
// Purpose: control and status registers of three linear regulators
// Assumes: serial host decoded upstream into a byte read/write port
// Notes: voltages reported in millivolts; zero marks an unavailable code
//
// Behaviour
// - power-good flags readable per regulator, third at bit 7
// - five-bit code: two band bits, three step bits to millivolts
// - six-bit first code decoded under range bit; high codes past 3.7 V unavailable
// - first regulator on when master enable low or power hold high
// - second and third follow their enable bits once master condition holds
// - discharge path applied only when bit set and regulator off
// - first code bits 5:0 and range bit 6 at 0x03, read/write
// - second code bits 4:0 at 0x41, read/write
`timescale 1ns/1ps
`default_nettype none
`include "ldocr_defines.svh"

module ldocr_regs
  import ldocr_pkg::*;
(
  input wire logic mclk, // 25 MHz clock
  input wire logic sys_rst, // async reset, high
  input wire logic [7:0] reg_addr, // register address
  input wire logic [7:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  output logic [7:0] reg_rdata, // read data, registered
  input wire logic master_enable_n, // master enable, low active
  input wire logic power_hold_input, // power hold, high active
  input wire logic [2:0] ldo_power_good_flag, // analog good comparators a,b,c
  output logic [2:0] ldo_enable, // regulator enables a,b,c
  output logic [2:0] ldo_discharge_on, // discharge switches a,b,c
  output var ldocr_mv_t ldo_a_mv, // first regulator target
  output var ldocr_mv_t ldo_b_mv, // second regulator target
  output var ldocr_mv_t ldo_c_mv // third regulator target
);

  logic [5:0] ldo_a_voltage_code_r;
  logic ldo_a_range_select_r;
  logic [4:0] ldo_b_voltage_code_r;
  logic [4:0] ldo_c_voltage_code_r;
  logic [2:0] ldo_enable_bit_r; // bit 0 unused: a follows pins
  logic [2:0] ldo_discharge_enable_r;
  logic misc_we_r;
  logic stat_we_r;
  logic master_on;
  logic [2:0] ldo_en_nxt;
  logic [7:0] rdata_nxt;

  // first regulator low range tables: 25 mV steps with irregular points
  function automatic ldocr_mv_t a_lo_mv(input logic [5:0] c);
    logic [11:0] base;
    base = 12'(645 + 405 * c[5:4] + 25 * c[3:0]);
    case (c)
      6'h0c, 6'h0d, 6'h0e, 6'h0f: a_lo_mv = 12'(base + 12'd5);
      6'h18, 6'h19, 6'h1a, 6'h1b, 6'h1c, 6'h1d, 6'h1e, 6'h1f: a_lo_mv = 12'(base + 12'd5);
      6'h25, 6'h26, 6'h27, 6'h28, 6'h29, 6'h2a, 6'h2b, 6'h2c, 6'h2d, 6'h2e, 6'h2f:
        a_lo_mv = 12'(base + 12'd5);
      6'h30: a_lo_mv = 12'd1860;
      6'h3e: a_lo_mv = 12'd2200;
      6'h3f: a_lo_mv = 12'd2245;
      default: begin
        if (c[5:4] == 2'b11) begin
          a_lo_mv = 12'(1865 + 25 * c[3:0]);
        end else begin
          a_lo_mv = base;
        end
      end
    endcase
  endfunction

  // -------------------------------------------------------------
  // voltage decode
  // -------------------------------------------------------------
  always_comb begin
    if (ldo_a_range_select_r) begin
      if (ldo_a_voltage_code_r > `LDOCR_A_HI_MAX_CODE) begin
        ldo_a_mv = 12'd0;
      end else begin
        ldo_a_mv = 12'(1250 + 50 * ldo_a_voltage_code_r);
      end
    end else begin
      ldo_a_mv = a_lo_mv(ldo_a_voltage_code_r);
    end
  end

  function automatic ldocr_mv_t bc_mv(input logic [4:0] c);
    case (c[4:3])
      2'b00: bc_mv = 12'(1400 + 100 * c[2:0]);
      2'b01: bc_mv = 12'(2150 + 50 * c[2:0]);
      2'b10: bc_mv = 12'(2550 + 50 * c[2:0]);
      default: bc_mv = 12'(3000 + 100 * c[2:0]);
    endcase
  endfunction

  assign ldo_b_mv = bc_mv(ldo_b_voltage_code_r);
  assign ldo_c_mv = bc_mv(ldo_c_voltage_code_r);

  // -------------------------------------------------------------
  // register writes
  // -------------------------------------------------------------
  // independent field writes
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ldo_a_voltage_code_r <= `LDOCR_RST_A_CODE;
      ldo_a_range_select_r <= `LDOCR_RST_BIT;
      ldo_b_voltage_code_r <= `LDOCR_RST_BC_CODE;
      ldo_c_voltage_code_r <= `LDOCR_RST_BC_CODE;
      ldo_enable_bit_r <= 3'h0;
      ldo_discharge_enable_r <= 3'h0;
      misc_we_r <= `LDOCR_RST_BIT;
      stat_we_r <= `LDOCR_RST_BIT;
    end else if (reg_wr) begin
      // read-only bits have no write path
      case (reg_addr)
        `LDOCR_ADDR_A_CFG: begin
          ldo_a_voltage_code_r <= reg_wdata[5:0];
          ldo_a_range_select_r <= reg_wdata[`LDOCR_A_RANGE_BIT];
        end
        `LDOCR_ADDR_MISC: misc_we_r <= reg_wdata[`LDOCR_WE_MISC_BIT];
        `LDOCR_ADDR_B_CFG: begin
          ldo_b_voltage_code_r <= reg_wdata[4:0];
          ldo_enable_bit_r[1] <= reg_wdata[`LDOCR_ON_BIT];
        end
        `LDOCR_ADDR_C_CFG: begin
          ldo_c_voltage_code_r <= reg_wdata[4:0];
          ldo_enable_bit_r[2] <= reg_wdata[`LDOCR_ON_BIT];
        end
        `LDOCR_ADDR_STAT: begin
          // write-exact bit simply stored as written
          stat_we_r <= reg_wdata[`LDOCR_WE_STAT_BIT];
          ldo_discharge_enable_r <= {reg_wdata[`LDOCR_DIS_C_BIT], reg_wdata[`LDOCR_DIS_B_BIT],
                                     reg_wdata[`LDOCR_DIS_A_BIT]};
        end
        default: ;
      endcase
    end
  end

  // -------------------------------------------------------------
  // enables and discharge
  // -------------------------------------------------------------
  // or of pin conditions
  assign master_on = ~master_enable_n | power_hold_input;

  always_comb begin
    ldo_en_nxt[0] = master_on;
    // per-regulator enables gated by master condition
    ldo_en_nxt[2:1] = ldo_enable_bit_r[2:1] & {2{master_on}};
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ldo_enable <= 3'h0;
      ldo_discharge_on <= 3'h0;
    end else begin
      ldo_enable <= ldo_en_nxt;
      ldo_discharge_on <= ldo_discharge_enable_r & ~ldo_en_nxt;
    end
  end

  // -------------------------------------------------------------
  // read back
  // -------------------------------------------------------------
  always_comb begin
    rdata_nxt = 8'h00;
    case (reg_addr)
      `LDOCR_ADDR_A_CFG: rdata_nxt = {1'b0, ldo_a_range_select_r, ldo_a_voltage_code_r};
      `LDOCR_ADDR_MISC: rdata_nxt[`LDOCR_WE_MISC_BIT] = misc_we_r;
      `LDOCR_ADDR_B_CFG: rdata_nxt = {2'b00, ldo_enable_bit_r[1], ldo_b_voltage_code_r};
      `LDOCR_ADDR_C_CFG: rdata_nxt = {2'b00, ldo_enable_bit_r[2], ldo_c_voltage_code_r};
      `LDOCR_ADDR_STAT: begin
        rdata_nxt[`LDOCR_PG_A_BIT] = ldo_power_good_flag[0] & ldo_enable[0];
        rdata_nxt[`LDOCR_PG_B_BIT] = ldo_power_good_flag[1] & ldo_enable[1];
        rdata_nxt[`LDOCR_PG_C_BIT] = ldo_power_good_flag[2] & ldo_enable[2];
        rdata_nxt[`LDOCR_DIS_A_BIT] = ldo_discharge_enable_r[0];
        rdata_nxt[`LDOCR_DIS_B_BIT] = ldo_discharge_enable_r[1];
        rdata_nxt[`LDOCR_DIS_C_BIT] = ldo_discharge_enable_r[2];
        rdata_nxt[`LDOCR_WE_STAT_BIT] = stat_we_r;
      end
      default: rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= rdata_nxt;
    end
  end

  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  a_a_enable_follows: assert property (@(posedge mclk) disable iff (sys_rst)
    ##1 ldo_enable[0] == $past(~master_enable_n | power_hold_input))
    else $error("first regulator enable wrong");
  a_bc_gated: assert property (@(posedge mclk) disable iff (sys_rst)
    !$past(master_on) |-> ldo_enable[2:1] == 2'b00)
    else $error("second or third on without master");
  a_discharge_off: assert property (@(posedge mclk) disable iff (sys_rst)
    (ldo_discharge_on & ldo_enable) == 3'h0)
    else $error("discharge while enabled");
  a_pg_read: assert property (@(posedge mclk) disable iff (sys_rst)
    reg_addr == `LDOCR_ADDR_STAT |=> reg_rdata[7] == $past(ldo_power_good_flag[2] & ldo_enable[2]))
    else $error("third power-good read wrong");
  a_b_code_wr: assert property (@(posedge mclk) disable iff (sys_rst)
    reg_wr && reg_addr == `LDOCR_ADDR_B_CFG |=> ldo_b_voltage_code_r == $past(reg_wdata[4:0]))
    else $error("second code not stored");
  a_a_code_wr: assert property (@(posedge mclk) disable iff (sys_rst)
    reg_wr && reg_addr == `LDOCR_ADDR_A_CFG |=> ##1 $past(reg_addr) != `LDOCR_ADDR_A_CFG ||
    reg_rdata[6:0] == $past(reg_wdata[6:0], 2))
    else $error("first code readback wrong");
  a_hi_unavail: assert property (@(posedge mclk) disable iff (sys_rst)
    ldo_a_range_select_r && ldo_a_voltage_code_r > 6'h31 |-> ldo_a_mv == 12'd0)
    else $error("unavailable code decoded");
  a_bc_decode: assert property (@(posedge mclk) disable iff (sys_rst)
    ldo_b_voltage_code_r == 5'h1f |-> ldo_b_mv == 12'd3700)
    else $error("top band decode wrong");
  a_ro_hold: assert property (@(posedge mclk) disable iff (sys_rst)
    reg_wr && reg_addr == `LDOCR_ADDR_STAT |=> $stable(ldo_enable_bit_r))
    else $error("status write changed enables");

endmodule
`default_nettype wire

// file: bench/ldocr_host.sv
// Purpose: host model driving the byte register port
// Assumes: one access per call, inputs moved 1 ns after the edge
// Notes: released write data is inverted so stale values show
`timescale 1ns/1ps
`default_nettype none
`include "ldocr_defines.svh"
module ldocr_host (
  input wire logic mclk, // clock
  input wire logic [7:0] reg_rdata, // read data
  output logic [7:0] reg_addr, // address
  output logic [7:0] reg_wdata, // write data
  output logic reg_wr // write strobe
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] m;
    m = (a == `LDOCR_ADDR_STAT) ? 8'hfd : ((a == `LDOCR_ADDR_MISC) ? 8'hdf : 8'hff);
    @(posedge mclk);
    #1;
    reg_addr = a;
    reg_wdata = d & m;
    reg_wr = 1'b1;
    @(posedge mclk);
    #1;
    reg_wr = 1'b0;
    reg_wdata = ~reg_wdata;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    #1;
    reg_addr = a;
    @(posedge mclk);
    #1;
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

// file: bench/tb_top.sv
// Purpose: register and enable checks of the regulator control block
// Assumes: reset values zero, good read as flag and enable
// Notes: expected millivolts written out from the code tables
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import ldocr_pkg::*;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic master_enable_n = 1'b1;
  logic power_hold_input = 1'b0;
  logic [2:0] ldo_power_good_flag = 3'b000;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
  logic reg_wr;
  logic [2:0] ldo_enable, ldo_discharge_on;
  ldocr_mv_t ldo_a_mv, ldo_b_mv, ldo_c_mv;
  int failures = 0;
  int tests_run = 0;
  logic [7:0] a_code [8] = '{8'h00, 8'h0c, 8'h1d, 8'h3f, 8'h40, 8'h71, 8'h72, 8'h7f};
  logic [11:0] a_mv [8] = '{12'd645, 12'd950, 12'd1380, 12'd2245, 12'd1250, 12'd3700, 12'd0, 12'd0};
  logic [7:0] bc_code [8] = '{8'h00, 8'h07, 8'h08, 8'h0f, 8'h10, 8'h17, 8'h18, 8'h1f};
  logic [11:0] bc_mv [8] = '{12'd1400, 12'd2100, 12'd2150, 12'd2500, 12'd2550, 12'd2900, 12'd3000, 12'd3700};
  always #20 mclk = ~mclk;
  ldocr_regs u_dut (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rdata(reg_rdata), .master_enable_n(master_enable_n),
    .power_hold_input(power_hold_input), .ldo_power_good_flag(ldo_power_good_flag),
    .ldo_enable(ldo_enable), .ldo_discharge_on(ldo_discharge_on), .ldo_a_mv(ldo_a_mv),
    .ldo_b_mv(ldo_b_mv), .ldo_c_mv(ldo_c_mv));
  ldocr_host u_host (.mclk(mclk), .reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr));
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    u_host.rd(a, d);
    chk({4'h0, d}, {4'h0, exp});
  endtask
  task automatic pause();
    repeat (3) @(posedge mclk);
    #1;
  endtask
  task automatic end_of_test();
    if (failures == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    #100000;
    failures++;
    end_of_test();
  end
  initial begin
    repeat (2) @(posedge mclk);
    #1;
    sys_rst = 1'b0;
    rchk(8'h43, 8'h00);
    chk(ldo_a_mv, 12'd645);
    chk(ldo_c_mv, 12'd1400);
    // first code with range, top bit read-only
    for (int i = 0; i < 8; i++) begin
      u_host.wr(8'h03, a_code[i] | 8'h80);
      rchk(8'h03, a_code[i]);
      chk(ldo_a_mv, a_mv[i]);
    end
    for (int i = 0; i < 8; i++) begin
      u_host.wr(8'h41, bc_code[i]);
      u_host.wr(8'h42, bc_code[7 - i]);
      rchk(8'h41, bc_code[i]);
      chk(ldo_b_mv, bc_mv[i]);
      chk(ldo_c_mv, bc_mv[7 - i]);
    end
    u_host.wr(8'h55, 8'hff);
    rchk(8'h55, 8'h00);
    u_host.wr(8'h40, 8'hff);
    rchk(8'h40, 8'h00);
    u_host.wr(8'h41, 8'h20);
    u_host.wr(8'h43, 8'h1c);
    // pin combinations, second on, third off
    for (int i = 0; i < 4; i++) begin
      {master_enable_n, power_hold_input} = 2'(i);
      pause();
      chk({9'h0, ldo_enable}, {10'h0, {2{~master_enable_n | power_hold_input}}});
      chk({9'h0, ldo_discharge_on}, {9'h0, 1'b1, {2{master_enable_n & ~power_hold_input}}});
    end
    u_host.wr(8'h42, 8'h20);
    pause();
    chk({9'h0, ldo_enable}, 12'h007);
    u_host.wr(8'h41, 8'h00);
    u_host.wr(8'h43, 8'h10);
    pause();
    chk({9'h0, ldo_discharge_on}, 12'h000);
    ldo_power_good_flag = 3'b111;
    u_host.wr(8'h43, 8'hff);
    rchk(8'h43, 8'hbc);
    ldo_power_good_flag = 3'b011;
    rchk(8'h43, 8'h3c);
    u_host.wr(8'h41, 8'h20);
    pause();
    chk({9'h0, ldo_discharge_on}, 12'h000);
    rchk(8'h43, 8'h7c);
    end_of_test();
  end
endmodule
`default_nettype wire
